// >>> rtl/nfc_defines.svh
// Constants of the numeric format converter: field positions, codes and timing.
`ifndef NFC_DEFINES_SVH
`define NFC_DEFINES_SVH

// ==================================================================
// Single-precision working format
`define NFC_F32_BIAS      127
`define NFC_F32_MW        23
`define NFC_F32_EMAX      8'hff
`define NFC_F32_INF       32'h7f800000
`define NFC_F32_QNAN      32'h7fc00000
`define NFC_F32_NEG_ONE   32'hbf800000

// ==================================================================
// Unsigned 10-bit float format
`define NFC_F10_BIAS      15
`define NFC_F10_MW        5
`define NFC_F10_EMAX      5'h1f
`define NFC_F10_MAXFIN    10'h3df
`define NFC_F10_INF       10'h3e0
`define NFC_F10_NAN       10'h3ff

// ==================================================================
// Fixed-point working precision and pipeline depth
`define NFC_FIX_FB        30
`define NFC_QFRAC         32
`define NFC_LATENCY       1

`endif

// >>> rtl/nfc_pkg.sv
// Types shared by the numeric format converter modules.
package nfc_pkg;

    // ==================================================================
    // Operation selector
    typedef enum logic [2:0] {
        NFC_OP_DEC10,
        NFC_OP_ENC10,
        NFC_OP_UN2F,
        NFC_OP_SN2F,
        NFC_OP_F2UN,
        NFC_OP_F2SN
    } nfc_op_e;

    // ==================================================================
    // Registered state of the converter
    typedef struct packed {
        logic        vld;
        logic [31:0] data;
    } nfc_state_s;

endpackage : nfc_pkg

// >>> rtl/nfc_fix2fp.sv
// Unsigned fixed-point magnitude plus sign to single-precision normaliser.
`timescale 1ns/1ps
`include "nfc_defines.svh"

module nfc_fix2fp import nfc_pkg::*; #(
    parameter int W  = 41,
    parameter int FW = 32
) (
    input  wire logic [W-1:0] mag,
    input  wire logic         sgn,
    output logic      [31:0]  fp
);

    int          pos;
    logic [W-1:0] norm;
    logic        rnd;
    logic        stk;
    logic [23:0] mr;
    logic [7:0]  ex;

    // ==================================================================
    // Leading-one search, shift and round to nearest even.
    always_comb begin
        pos = 0;
        for (int i = 0; i < W; i++) begin
            if (mag[i]) begin
                pos = i;
            end
        end
        norm = mag << (W - 1 - pos);
        rnd  = norm[W-25];
        stk  = |norm[W-26:0];
        mr   = {1'b0, norm[W-2 -: 23]};
        if (rnd && (stk || mr[0])) begin
            mr = mr + 24'h000001;
        end
        ex = 8'(pos - FW + `NFC_F32_BIAS) + {7'h00, mr[23]};
        fp = (mag == '0) ? 32'h00000000 : {sgn, ex, mr[22:0]};
    end

endmodule : nfc_fix2fp

// >>> rtl/nfc_core.sv
// Numeric format converter: 10-bit float and normalized fixed-point datapath.
//
// Functional notes
// - 10-bit float: no sign, 5+5 fields.
// - Exponent is upper five, mantissa lower five.
// - Decode zero, denormal, normal, infinity, NaN.
// - Encoder rounds finite inputs to nearest.
// - Truncation toward zero allowed as option.
// - Negative finite inputs encode as zero.
// - Large positives saturate to largest finite value.
// - Minus infinity zero, plus infinity kept, NaN positive.
// - Special inputs never stall the datapath.
// - Denormal 10-bit inputs decode deterministically.
// - Unsigned normalized: c over two-to-b minus one.
// - Signed method one: (2c+1) over full range.
// - Signed method two: clamped c over half range.
// - Float to unsigned: clamp, scale, cast.
// - Float to signed one: clamp, scale, subtract, halve.
// - Float to signed two: scale by half range.
// - Signed results cast to exactly b bits.
// - Nominal width b used exactly.
`timescale 1ns/1ps
`include "nfc_defines.svh"

module nfc_core import nfc_pkg::*; #(
    parameter int B_W = 8
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        req_valid,
    input  wire nfc_op_e     req_op,
    input  wire logic        req_meth,
    input  wire logic        req_trunc,
    input  wire logic [31:0] req_data,
    output logic             res_valid,
    output logic      [31:0] res_data
);

    localparam int QW = B_W + 1 + `NFC_QFRAC;
    localparam logic [QW-1:0] DF_Q = QW'((2 ** B_W) - 1);
    localparam logic [QW-1:0] DH_Q = QW'((2 ** (B_W - 1)) - 1);
    localparam logic signed [63:0] DF_L = 64'((2 ** B_W) - 1);
    localparam logic signed [63:0] DH_L = 64'((2 ** (B_W - 1)) - 1);
    localparam logic [63:0] ONE_FB = 64'h1 << `NFC_FIX_FB;

    nfc_state_s st_q;
    nfc_state_s st_d;

    // ==================================================================
    // Single-precision input fields
    logic        f_sgn;
    logic [7:0]  f_exp;
    logic [22:0] f_man;
    logic        f_nan;
    logic [23:0] f_sig;

    assign f_sgn = req_data[31];
    assign f_exp = req_data[30:23];
    assign f_man = req_data[22:0];
    assign f_nan = (f_exp == `NFC_F32_EMAX) && (f_man != '0);
    assign f_sig = {1'b1, f_man};

    // ==================================================================
    // 10-bit float decode
    logic [4:0]  d_exp;
    logic [4:0]  d_man;
    logic [23:0] d_shf;
    logic [31:0] dec_fp;
    int          d_pos;

    assign d_exp = req_data[9:5];
    assign d_man = req_data[4:0];

    always_comb begin
        d_pos = 0;
        for (int i = 0; i < `NFC_F10_MW; i++) begin
            if (d_man[i]) begin
                d_pos = i;
            end
        end
        d_shf = {19'h00000, d_man} << (`NFC_F32_MW - d_pos);
        if (d_exp == 5'h00) begin
            if (d_man == 5'h00) begin
                dec_fp = 32'h00000000;
            end else begin
                // Denormal: the leading mantissa one becomes the hidden bit.
                dec_fp = {1'b0,
                          8'(d_pos + `NFC_F32_BIAS - (`NFC_F10_BIAS - 1) - `NFC_F10_MW),
                          d_shf[22:0]};
            end
        end else if (d_exp == `NFC_F10_EMAX) begin
            dec_fp = (d_man == 5'h00) ? `NFC_F32_INF
                                      : (`NFC_F32_QNAN | {9'h000, d_man, 18'h00000});
        end else begin
            dec_fp = {1'b0, 8'(int'(d_exp) + `NFC_F32_BIAS - `NFC_F10_BIAS),
                      d_man, 18'h00000};
        end
    end

    // ==================================================================
    // 10-bit float encode
    int          e_ee;
    int          e_sh;
    logic [31:0] e_k;
    logic [31:0] e_rem;
    logic [31:0] e_half;
    logic [31:0] e_code;
    logic [9:0]  enc10;

    always_comb begin
        e_ee = int'(f_exp) - (`NFC_F32_BIAS - `NFC_F10_BIAS);
        if (e_ee >= 1) begin
            e_sh = `NFC_F32_MW - `NFC_F10_MW;
        end else begin
            e_sh = `NFC_F32_MW - `NFC_F10_MW + 1 - e_ee;
        end
        if (e_sh > 31) begin
            e_sh = 31;
        end
        e_k    = {8'h00, f_sig} >> e_sh;
        e_rem  = {8'h00, f_sig} & ((32'h1 << e_sh) - 32'h1);
        e_half = 32'h1 << (e_sh - 1);
        e_code = (e_ee >= 1) ? ((32'(e_ee - 1) << `NFC_F10_MW) + e_k) : e_k;
        if (!req_trunc && ((e_rem > e_half) || ((e_rem == e_half) && e_k[0]))) begin
            e_code = e_code + 32'h1;
        end
        if (f_nan) begin
            enc10 = `NFC_F10_NAN;
        end else if (f_sgn) begin
            enc10 = 10'h000;
        end else if (f_exp == `NFC_F32_EMAX) begin
            enc10 = `NFC_F10_INF;
        end else if (f_exp == 8'h00) begin
            enc10 = 10'h000;
        end else if (e_ee >= int'(`NFC_F10_EMAX) || e_code > 32'(`NFC_F10_MAXFIN)) begin
            enc10 = `NFC_F10_MAXFIN;
        end else begin
            enc10 = e_code[9:0];
        end
    end

    // ==================================================================
    // Normalized fixed-point to float
    logic signed [B_W-1:0] c_s;
    logic signed [B_W:0]   c_n1;
    logic [B_W:0]          mag_f;
    logic [B_W:0]          mag_h;
    logic                  neg_f;
    logic                  neg_h;
    logic [QW-1:0]         q_f;
    logic [QW-1:0]         q_h;
    logic [31:0]           fp_f;
    logic [31:0]           fp_h;
    logic [31:0]           sn2f_fp;

    assign c_s  = $signed(req_data[B_W-1:0]);
    assign c_n1 = {c_s, 1'b1};

    always_comb begin
        if (req_op == NFC_OP_UN2F) begin
            neg_f = 1'b0;
            mag_f = {1'b0, req_data[B_W-1:0]};
        end else begin
            neg_f = c_n1[B_W];
            mag_f = c_n1[B_W] ? (B_W + 1)'(-c_n1) : c_n1;
        end
        neg_h = c_s[B_W-1];
        mag_h = c_s[B_W-1] ? (B_W + 1)'(-c_s) : (B_W + 1)'(c_s);
    end

    assign q_f = {mag_f, {`NFC_QFRAC{1'b0}}} / DF_Q;
    assign q_h = {mag_h, {`NFC_QFRAC{1'b0}}} / DH_Q;

    nfc_fix2fp #(
        .W  (QW),
        .FW (`NFC_QFRAC)
    ) u_norm_full (
        .mag (q_f),
        .sgn (neg_f),
        .fp  (fp_f)
    );

    nfc_fix2fp #(
        .W  (QW),
        .FW (`NFC_QFRAC)
    ) u_norm_half (
        .mag (q_h),
        .sgn (neg_h),
        .fp  (fp_h)
    );

    // The most negative code lies outside the half-range scale and clamps.
    assign sn2f_fp = (req_data[B_W-1:0] == {1'b1, {(B_W - 1){1'b0}}}) ?
                     `NFC_F32_NEG_ONE : fp_h;

    // ==================================================================
    // Float to normalized fixed-point
    logic [30:0]          x_mag;
    logic signed [63:0]   x_s;
    logic signed [63:0]   x_p;
    logic [63:0]          x_pm;
    logic [63:0]          x_r;
    logic                 x_neg;
    int                   x_sh;
    logic [B_W-1:0]       fix_b;
    logic [31:0]          fix_out;

    always_comb begin
        if (f_nan) begin
            x_mag = 31'h00000000;
        end else if (f_exp >= 8'(`NFC_F32_BIAS)) begin
            x_mag = ONE_FB[30:0];
        end else if ((`NFC_F32_BIAS - int'(f_exp)) > `NFC_FIX_FB || f_exp == 8'h00) begin
            x_mag = 31'h00000000;
        end else begin
            x_mag = {f_sig, 7'h00} >> (`NFC_F32_BIAS - int'(f_exp));
        end
        if (req_op == NFC_OP_F2UN) begin
            x_s = f_sgn ? 64'sh0 : $signed({33'h0, x_mag});
        end else begin
            x_s = f_sgn ? -$signed({33'h0, x_mag}) : $signed({33'h0, x_mag});
        end
        if (req_op == NFC_OP_F2UN) begin
            x_p  = x_s * DF_L;
            x_sh = `NFC_FIX_FB;
        end else if (!req_meth) begin
            x_p  = x_s * DF_L - $signed(ONE_FB);
            x_sh = `NFC_FIX_FB + 1;
        end else begin
            x_p  = x_s * DH_L;
            x_sh = `NFC_FIX_FB;
        end
        x_neg = x_p[63];
        x_pm  = x_neg ? 64'(-x_p) : 64'(x_p);
        x_r   = (x_pm + (64'h1 << (x_sh - 1))) >> x_sh;
        fix_b = x_neg ? B_W'(-x_r) : x_r[B_W-1:0];
        if (req_op == NFC_OP_F2UN) begin
            fix_out = {{(32 - B_W){1'b0}}, fix_b};
        end else begin
            fix_out = {{(32 - B_W){fix_b[B_W-1]}}, fix_b};
        end
    end

    // ==================================================================
    // Result selection and pipeline register
    always_comb begin
        st_d.vld = req_valid;
        st_d.data = st_q.data;
        if (req_valid) begin
            case (req_op)
                NFC_OP_DEC10: begin
                    st_d.data = dec_fp;
                end
                NFC_OP_ENC10: begin
                    st_d.data = {22'h000000, enc10};
                end
                NFC_OP_UN2F: begin
                    st_d.data = fp_f;
                end
                NFC_OP_SN2F: begin
                    st_d.data = req_meth ? sn2f_fp : fp_f;
                end
                NFC_OP_F2UN, NFC_OP_F2SN: begin
                    st_d.data = fix_out;
                end
                default: begin
                    st_d.data = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign res_valid = st_q.vld;
    assign res_data  = st_q.data;

endmodule : nfc_core

// >>> testbench/nfc_core_asserts.sv
// Port checker for the numeric format converter.
`timescale 1ns/1ps
module nfc_core_asserts import nfc_pkg::*; #(
    parameter int B_W = 8
) (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        req_valid,
    input wire nfc_op_e     req_op,
    input wire logic        req_meth,
    input wire logic        req_trunc,
    input wire logic [31:0] req_data,
    input wire logic        res_valid,
    input wire logic [31:0] res_data
);
    // ==================================================================
    // Operand classes
    logic in_nan;
    logic enc;
    assign in_nan = req_data[30:23] == 8'hff && req_data[22:0] != 23'h0;
    assign enc = req_valid && req_op == NFC_OP_ENC10;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // ==================================================================
    // Handshake
    sequence s_lone_req;
        req_valid ##1 !req_valid;
    endsequence
    sequence s_one_pulse;
        res_valid ##1 !res_valid;
    endsequence

    a_result_latency: assert property (req_valid |=> res_valid)
        else $error("result strobe missing one cycle after request");
    a_no_spurious: assert property (!req_valid |=> !res_valid)
        else $error("result strobe without request");
    a_single_pulse: assert property (s_lone_req |-> s_one_pulse)
        else $error("result strobe not a single pulse");
    a_result_hold: assert property (!req_valid |=> $stable(res_data))
        else $error("result data changed without request");
    a_reset_clear: assert property (disable iff (1'b0)
        rst |=> !res_valid && res_data == 32'h0)
        else $error("reset did not clear the result");

    // ==================================================================
    // Format rules
    a_dec_inf: assert property (req_valid && req_op == NFC_OP_DEC10 &&
        req_data[9:0] == 10'h3e0 |=> res_data == 32'h7f800000)
        else $error("decode of infinity wrong");
    a_dec_nan: assert property (req_valid && req_op == NFC_OP_DEC10 &&
        req_data[9:5] == 5'h1f && req_data[4:0] != 5'h0
        |=> res_data[30:23] == 8'hff && res_data[22:0] != 23'h0)
        else $error("decode of NaN wrong");
    a_enc_width: assert property (enc |=> res_data[31:10] == 22'h0)
        else $error("encoded value wider than ten bits");
    a_enc_negative: assert property (enc && req_data[31] && !in_nan
        |=> res_data == 32'h0)
        else $error("negative input not encoded as zero");
    a_enc_nan: assert property (enc && in_nan |=> res_data == 32'h3ff)
        else $error("NaN not encoded as positive NaN");
    a_f2un_clamp: assert property (req_valid && req_op == NFC_OP_F2UN &&
        !req_data[31] && req_data[30:23] >= 8'h7f && !in_nan
        |=> res_data == 32'((64'd1 << B_W) - 1))
        else $error("unsigned clamp at one wrong");
endmodule : nfc_core_asserts

bind nfc_core nfc_core_asserts #(.B_W(B_W)) nfc_core_asserts_inst (
    .core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req_op(req_op),
    .req_meth(req_meth), .req_trunc(req_trunc), .req_data(req_data),
    .res_valid(res_valid), .res_data(res_data));

// >>> testbench/nfc_src.sv
// Model of the pipeline stage that feeds the converter and takes its results.
`timescale 1ns/1ps
module nfc_src import nfc_pkg::*; (
    input  wire logic        core_clk,
    input  wire logic        res_valid,
    input  wire logic [31:0] res_data,
    output logic             req_valid,
    output nfc_op_e          req_op,
    output logic             req_meth,
    output logic             req_trunc,
    output logic      [31:0] req_data
);
    initial begin
        req_valid = 1'b0;
        req_op = NFC_OP_DEC10;
        req_meth = 1'b0;
        req_trunc = 1'b0;
        req_data = 32'h0;
    end

    // Called at a falling edge; presents one request and samples its answer.
    task automatic drive(input nfc_op_e op, input logic meth, input logic trunc,
                         input logic [31:0] d, input bit last,
                         output logic [31:0] r, output logic ok);
        req_valid = 1'b1;
        req_op = op;
        req_meth = meth;
        req_trunc = trunc;
        req_data = d;
        @(negedge core_clk);
        ok = res_valid;
        r = res_data;
        if (last) begin
            req_valid = 1'b0;
            req_data = ~d;
            @(negedge core_clk);
        end
    endtask : drive
endmodule : nfc_src

// >>> testbench/tb.sv
// Self-checking testbench of the numeric format converter.
`timescale 1ns/1ps
module tb import nfc_pkg::*; ;
    localparam int B_W = 8;
    logic        core_clk = 1'b0;
    logic        rst;
    logic        req_valid;
    nfc_op_e     req_op;
    logic        req_meth;
    logic        req_trunc;
    logic [31:0] req_data;
    logic        res_valid;
    logic [31:0] res_data;
    int          n_fail;
    int          n_compared;

    nfc_core #(.B_W(B_W)) nfc_core_inst (.core_clk(core_clk), .rst(rst),
        .req_valid(req_valid), .req_op(req_op), .req_meth(req_meth),
        .req_trunc(req_trunc), .req_data(req_data), .res_valid(res_valid),
        .res_data(res_data));
    nfc_src nfc_src_inst (.core_clk(core_clk), .res_valid(res_valid),
        .res_data(res_data), .req_valid(req_valid), .req_op(req_op),
        .req_meth(req_meth), .req_trunc(req_trunc), .req_data(req_data));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ==================================================================
    // Comparison and transfer helpers
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic chk_bit(input string what, input logic e, input logic g);
        chk(what, {31'h0, e}, {31'h0, g});
    endtask : chk_bit

    task automatic run(input string what, input nfc_op_e op, input logic meth,
                       input logic trunc, input logic [31:0] d,
                       input logic [31:0] e, input bit last = 1'b1);
        logic [31:0] r;
        logic        ok;
        nfc_src_inst.drive(op, meth, trunc, d, last, r, ok);
        chk_bit({what, " valid"}, 1'b1, ok);
        chk(what, e, r);
    endtask : run

    // ==================================================================
    // Scenarios
    task automatic t_decode;
        run("dec zero", NFC_OP_DEC10, 0, 0, 32'h000, 32'h00000000);
        run("dec den1", NFC_OP_DEC10, 0, 0, 32'h001, 32'h36000000);
        run("dec den31", NFC_OP_DEC10, 0, 0, 32'h01f, 32'h38780000);
        run("dec e1m1", NFC_OP_DEC10, 0, 0, 32'h021, 32'h38840000);
        run("dec max", NFC_OP_DEC10, 0, 0, 32'h3df, 32'h477c0000);
        run("dec inf", NFC_OP_DEC10, 0, 0, 32'h3e0, 32'h7f800000);
    endtask : t_decode

    task automatic t_encode;
        run("enc one", NFC_OP_ENC10, 0, 0, 32'h3f800000, 32'h1e0);
        run("enc tie", NFC_OP_ENC10, 0, 0, 32'h3f860000, 32'h1e2);
        run("enc tie tr", NFC_OP_ENC10, 0, 1, 32'h3f860000, 32'h1e1);
        run("enc up", NFC_OP_ENC10, 0, 0, 32'h3f820001, 32'h1e1);
        run("enc up tr", NFC_OP_ENC10, 0, 1, 32'h3f820001, 32'h1e0);
        run("enc neg", NFC_OP_ENC10, 0, 0, 32'hbf800000, 32'h000);
        run("enc big", NFC_OP_ENC10, 0, 0, 32'h49742400, 32'h3df);
        run("enc ninf", NFC_OP_ENC10, 0, 0, 32'hff800000, 32'h000);
        run("enc nnan", NFC_OP_ENC10, 0, 0, 32'hffc00000, 32'h3ff);
    endtask : t_encode

    task automatic t_to_float;
        run("un max", NFC_OP_UN2F, 0, 0, 32'hff, 32'h3f800000);
        run("un zero", NFC_OP_UN2F, 0, 0, 32'h00, 32'h00000000);
        run("sn0 min", NFC_OP_SN2F, 0, 0, 32'h80, 32'hbf800000);
        run("sn0 max", NFC_OP_SN2F, 0, 0, 32'h7f, 32'h3f800000);
        run("sn1 min", NFC_OP_SN2F, 1, 0, 32'h80, 32'hbf800000);
        run("sn1 m127", NFC_OP_SN2F, 1, 0, 32'h81, 32'hbf800000);
        run("sn1 zero", NFC_OP_SN2F, 1, 0, 32'h00, 32'h00000000);
    endtask : t_to_float

    task automatic t_to_fixed;
        run("fu half", NFC_OP_F2UN, 0, 0, 32'h3f000000, 32'h80);
        run("fu two", NFC_OP_F2UN, 0, 0, 32'h40000000, 32'hff);
        run("fu neg", NFC_OP_F2UN, 0, 0, 32'hbf800000, 32'h00);
        run("fs0 one", NFC_OP_F2SN, 0, 0, 32'h3f800000, 32'h7f);
        run("fs0 mone", NFC_OP_F2SN, 0, 0, 32'hbf800000, 32'hffffff80);
        run("fs1 mtwo", NFC_OP_F2SN, 1, 0, 32'hc0000000, 32'hffffff81);
        run("fs1 mhalf", NFC_OP_F2SN, 1, 0, 32'hbf000000, 32'hffffffc0);
        run("fs1 half", NFC_OP_F2SN, 1, 0, 32'h3f000000, 32'h40);
    endtask : t_to_fixed

    task automatic t_back_to_back;
        run("b2b fu", NFC_OP_F2UN, 0, 0, 32'h3f800000, 32'hff, 0);
        run("b2b inf", NFC_OP_ENC10, 0, 0, 32'h7f800000, 32'h3e0, 0);
        run("b2b undef", nfc_op_e'(3'h6), 0, 0, 32'h12345678, 32'h0, 0);
        run("b2b nan", NFC_OP_DEC10, 0, 0, 32'h3ff, 32'h7ffc0000);
        chk_bit("b2b idle", 1'b0, res_valid);
    endtask : t_back_to_back

    task automatic t_mid_reset;
        run("pre rst", NFC_OP_UN2F, 0, 0, 32'hff, 32'h3f800000);
        rst = 1'b1;
        @(negedge core_clk);
        chk_bit("rst valid", 1'b0, res_valid);
        chk("rst data", 32'h0, res_data);
        rst = 1'b0;
        @(negedge core_clk);
    endtask : t_mid_reset

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    initial begin
        n_fail = 0;
        n_compared = 0;
        rst = 1'b1;
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        t_decode();
        t_mid_reset();
        t_encode();
        t_to_float();
        t_to_fixed();
        t_back_to_back();
        test_done();
    end
endmodule : tb
